// File: hdl/sil_params.svh
// Contract
// R01 - Error lamp dark normally, steady on while an internal fault is present.
// R02 - Error lamp blinks while a warning is present, unlike the steady fault.
// R03 - Bus activity lamp dark when idle, short flash on each bus activity.
// R04 - Locate command gives three quick pulses on bus and setup lamps.
// R05 - Setup lamp steady while initializing, changing mode or programming.
// R06 - Input valid lamp on exactly while a valid input is detected.
// R07 - Remote override, both frame sync and reference lamps stay dark.
// R08 - Power lamp steady on while the supply conversion works.
// R09 - After power-up the setup lamp holds on for the initialization time.
// R10 - Lamp timings come from a writable prescaler; fault beats warning. The power-up setup hold of R09 counts raw clocks, not prescaler ticks.
`ifndef SIL_PARAMS_SVH
`define SIL_PARAMS_SVH

`define SIL_CLK_MHZ        100
`define SIL_ADDR_W         4
`define SIL_OFF_PRESCALE   4'h0
`define SIL_OFF_STATUS     4'h4
`define SIL_OFF_MASK       4'h8
`define SIL_OFF_STATE      4'hc

`define SIL_PRESCALE_W     24
`define SIL_CNT_W          8
`define SIL_EV_W           4
`define SIL_EV_FAULT       0
`define SIL_EV_WARN        1
`define SIL_EV_LOCATE      2
`define SIL_EV_LOST        3
`define SIL_MASK_RST       4'h0

`define SIL_TICK_TIME_US   1000
`define SIL_TICK_CYCLES    (`SIL_TICK_TIME_US * `SIL_CLK_MHZ)
`define SIL_INIT_TIME_MS   2000
`define SIL_INIT_CYCLES    (`SIL_INIT_TIME_MS * 1000 * `SIL_CLK_MHZ)
`define SIL_BLINK_TIME_MS  250
`define SIL_FLASH_TIME_MS  50
`define SIL_PULSE_TIME_MS  100
`define SIL_BLINK_TICKS    (`SIL_BLINK_TIME_MS * 1000 / `SIL_TICK_TIME_US)
`define SIL_FLASH_TICKS    (`SIL_FLASH_TIME_MS * 1000 / `SIL_TICK_TIME_US)
`define SIL_PULSE_TICKS    (`SIL_PULSE_TIME_MS * 1000 / `SIL_TICK_TIME_US)
`define SIL_LOC_PULSES     3

`endif

// File: hdl/sil_pkg.sv
`default_nettype none
`include "sil_params.svh"

package sil_pkg;

  typedef enum logic [2:0] {
    SIL_LOC_IDLE = 3'b001,
    SIL_LOC_ON   = 3'b010,
    SIL_LOC_OFF  = 3'b100
  } sil_loc_type;

  typedef struct packed {
    logic fault;
    logic warning;
    logic bus_activity;
    logic locate;
    logic setup_busy;
    logic input_valid;
    logic power_good;
  } sil_cond_type;

  typedef struct packed {
    logic error_indicator;
    logic bus_activity_indicator;
    logic setup_activity_indicator;
    logic power_indicator;
    logic input_valid_indicator;
    logic remote_override_indicator;
    logic frame_sync_indicator_a;
    logic frame_sync_indicator_b;
    logic reference_input_indicator;
  } sil_lamps_type;

  typedef struct packed {
    sil_loc_type                  loc;
    logic [1:0]                   loc_n;
    logic [`SIL_CNT_W-1:0]        loc_cnt;
    logic [`SIL_PRESCALE_W-1:0]   pre_cnt;
    logic [`SIL_PRESCALE_W-1:0]   prescale;
    logic                         tick;
    logic [`SIL_CNT_W-1:0]        blink_cnt;
    logic                         blink_ph;
    logic [`SIL_CNT_W-1:0]        flash_cnt;
    logic [31:0]                  init_cnt;
    logic                         init_done;
    logic                         fault_d;
    logic                         warning_d;
    logic                         valid_d;
    logic [`SIL_EV_W-1:0]         status;
    logic [`SIL_EV_W-1:0]         mask;
    logic [31:0]                  rd_data;
    logic                         irq;
    sil_lamps_type                lamps;
  } sil_state_type;

endpackage : sil_pkg
`default_nettype wire

// File: hdl/sil_indicators.sv
`timescale 1ns/100ps
`default_nettype none
`include "sil_params.svh"

module sil_indicators #(
  parameter int unsigned TICK_CYCLES = `SIL_TICK_CYCLES,
  parameter int unsigned INIT_CYCLES = `SIL_INIT_CYCLES
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire sil_pkg::sil_cond_type   cond,
  input  wire logic [`SIL_ADDR_W-1:0]  addr,
  input  wire logic [31:0]             wr_data,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output var  logic [31:0]             rd_data,
  output var  logic                    irq,
  output var  sil_pkg::sil_lamps_type  lamps
);
  import sil_pkg::*;

  localparam logic [`SIL_CNT_W-1:0] BLINK_T =
    `SIL_CNT_W'(`SIL_BLINK_TICKS);
  localparam logic [`SIL_CNT_W-1:0] FLASH_T =
    `SIL_CNT_W'(`SIL_FLASH_TICKS);
  localparam logic [`SIL_CNT_W-1:0] PULSE_T =
    `SIL_CNT_W'(`SIL_PULSE_TICKS);
  localparam logic [1:0] LAST_PULSE = 2'(`SIL_LOC_PULSES - 1);
  localparam logic [31:0] INIT_LAST = 32'(INIT_CYCLES - 1);
  localparam logic [`SIL_PRESCALE_W-1:0] PRESCALE_RST =
    `SIL_PRESCALE_W'(TICK_CYCLES - 1);

  // Setup lamp starts lit so initialization shows from the first cycle
  localparam sil_state_type ST_RST = '{
    loc:      SIL_LOC_IDLE,
    prescale: PRESCALE_RST,
    mask:     `SIL_MASK_RST,
    lamps:    '{setup_activity_indicator: 1'b1, default: 1'b0},
    default:  '0
  };

  sil_state_type             st;
  sil_state_type             n;
  logic [`SIL_EV_W-1:0]      ev;
  logic [`SIL_EV_W-1:0]      clr;
  logic                      locating;
  logic                      loc_busy;

  always_comb begin
    n        = st;
    ev       = '0;
    clr      = '0;
    locating = 1'b0;
    loc_busy = 1'b0;

    // Prescaler holds period minus one; zero gives a tick every cycle
    n.tick = 1'b0;
    if (st.pre_cnt >= st.prescale) begin
      n.pre_cnt = '0;
      n.tick    = 1'b1; // R10
    end else begin
      n.pre_cnt = st.pre_cnt + 1'b1;
    end

    // Blink phase toggles every half period of ticks
    if (st.tick) begin
      if (st.blink_cnt == '0) begin
        n.blink_cnt = BLINK_T - 1'b1;
        n.blink_ph  = ~st.blink_ph; // R02
      end else begin
        n.blink_cnt = st.blink_cnt - 1'b1;
      end
    end

    // A flash is not retriggered while lit, so a busy bus still blinks
    if (cond.bus_activity && st.flash_cnt == '0) begin
      n.flash_cnt = FLASH_T; // R03
    end else if (st.tick && st.flash_cnt != '0) begin
      n.flash_cnt = st.flash_cnt - 1'b1;
    end

    // A new locate command restarts the pulse train
    if (cond.locate) begin
      n.loc     = SIL_LOC_ON; // R04
      n.loc_cnt = PULSE_T;
      n.loc_n   = '0;
    end else begin
      unique case (st.loc)
        SIL_LOC_IDLE: begin
          n.loc = SIL_LOC_IDLE;
        end
        SIL_LOC_ON: begin
          if (st.tick) begin
            if (st.loc_cnt <= 8'h01) begin
              n.loc     = SIL_LOC_OFF;
              n.loc_cnt = PULSE_T;
            end else begin
              n.loc_cnt = st.loc_cnt - 1'b1;
            end
          end
        end
        SIL_LOC_OFF: begin
          if (st.tick) begin
            if (st.loc_cnt > 8'h01) begin
              n.loc_cnt = st.loc_cnt - 1'b1;
            end else if (st.loc_n == LAST_PULSE) begin
              n.loc = SIL_LOC_IDLE; // R04
            end else begin
              n.loc     = SIL_LOC_ON;
              n.loc_n   = st.loc_n + 1'b1;
              n.loc_cnt = PULSE_T;
            end
          end
        end
        default: begin
          n.loc = SIL_LOC_IDLE;
        end
      endcase
    end

    // Power-up hold counts raw clocks, not ticks, so it ignores prescale
    if (!st.init_done) begin
      if (st.init_cnt >= INIT_LAST) begin
        n.init_done = 1'b1; // R09
      end else begin
        n.init_cnt = st.init_cnt + 32'h1;
      end
    end

    locating = (n.loc == SIL_LOC_ON);
    loc_busy = (n.loc != SIL_LOC_IDLE);

    if (cond.fault) begin
      n.lamps.error_indicator = 1'b1; // R01 R10
    end else if (cond.warning) begin
      n.lamps.error_indicator = n.blink_ph; // R02
    end else begin
      n.lamps.error_indicator = 1'b0; // R01
    end

    n.lamps.bus_activity_indicator =
      loc_busy ? locating : (n.flash_cnt != '0); // R03 R04
    n.lamps.setup_activity_indicator =
      loc_busy ? locating : (cond.setup_busy || !n.init_done); // R05 R09
    n.lamps.power_indicator = cond.power_good; // R08
    n.lamps.input_valid_indicator = cond.input_valid; // R06
    n.lamps.remote_override_indicator = 1'b0; // R07
    n.lamps.frame_sync_indicator_a = 1'b0; // R07
    n.lamps.frame_sync_indicator_b = 1'b0; // R07
    n.lamps.reference_input_indicator = 1'b0; // R07

    n.fault_d   = cond.fault;
    n.warning_d = cond.warning;
    n.valid_d   = cond.input_valid;
    ev[`SIL_EV_FAULT]  = cond.fault & ~st.fault_d;
    ev[`SIL_EV_WARN]   = cond.warning & ~st.warning_d;
    ev[`SIL_EV_LOCATE] = cond.locate;
    ev[`SIL_EV_LOST]   = st.valid_d & ~cond.input_valid;

    if (wr_en) begin
      unique case (addr)
        `SIL_OFF_PRESCALE: n.prescale = wr_data[`SIL_PRESCALE_W-1:0];
        `SIL_OFF_MASK:     n.mask = wr_data[`SIL_EV_W-1:0];
        default: begin
        end
      endcase
    end

    n.rd_data = '0;
    if (rd_en) begin
      unique case (addr)
        `SIL_OFF_PRESCALE: n.rd_data = 32'(st.prescale);
        `SIL_OFF_STATUS: begin
          n.rd_data = 32'(st.status);
          clr       = st.status;
        end
        `SIL_OFF_MASK:     n.rd_data = 32'(st.mask);
        `SIL_OFF_STATE:    n.rd_data = 32'({st.loc, st.init_done, st.lamps});
        default:           n.rd_data = '0;
      endcase
    end

    // An event in the clearing cycle survives the read
    n.status = (st.status & ~clr) | ev;
    n.irq    = |(n.status & n.mask);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RST;
    end else begin
      st <= n;
    end
  end

  assign rd_data = st.rd_data;
  assign irq     = st.irq;
  assign lamps   = st.lamps;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  fault_steady_a: assert property ( // R01
    cond.fault |=> lamps.error_indicator [*1]
  ) else $error("error lamp not steady under fault");

  error_dark_a: assert property ( // R01
    (!cond.fault && !cond.warning) |=> !lamps.error_indicator
  ) else $error("error lamp lit with no fault or warning");

  warn_blink_a: assert property ( // R02
    (!cond.fault && cond.warning)
      |=> (lamps.error_indicator == st.blink_ph)
  ) else $error("error lamp does not follow blink phase");

  bus_idle_a: assert property ( // R03
    (st.loc == SIL_LOC_IDLE && !cond.locate && st.flash_cnt == '0
      && !cond.bus_activity) |=> !lamps.bus_activity_indicator
  ) else $error("bus lamp lit while bus idle");

  // A flash already lit is left to run out, so only a dark lamp retriggers
  flash_start_a: assert property ( // R03
    (st.loc == SIL_LOC_IDLE && cond.bus_activity && !cond.locate
      && st.flash_cnt == '0) |=> lamps.bus_activity_indicator
  ) else $error("bus activity gave no flash");

  locate_pulse_a: assert property ( // R04
    cond.locate |=> (lamps.bus_activity_indicator
      && lamps.setup_activity_indicator && st.loc_n == 2'h0)
  ) else $error("locate did not start a pulse on both lamps");

  // Compare against the pulse number that was just finished
  locate_count_a: assert property ( // R04
    (st.loc == SIL_LOC_OFF && st.tick && st.loc_cnt <= 8'h01
      && !cond.locate) |=> (st.loc == SIL_LOC_IDLE)
      == ($past(st.loc_n) == LAST_PULSE)
  ) else $error("locate pulse train length wrong");

  setup_busy_a: assert property ( // R05
    (cond.setup_busy && st.loc == SIL_LOC_IDLE && !cond.locate)
      |=> lamps.setup_activity_indicator
  ) else $error("setup lamp dark while busy");

  // Release edge skipped: the lamps still hold reset values after it
  valid_follow_a: assert property ( // R06
    rst_n |=> (lamps.input_valid_indicator == $past(cond.input_valid))
  ) else $error("valid lamp does not follow input");

  unused_dark_a: assert property ( // R07
    !(lamps.remote_override_indicator || lamps.frame_sync_indicator_a
      || lamps.frame_sync_indicator_b || lamps.reference_input_indicator)
  ) else $error("unused lamp lit");

  power_follow_a: assert property ( // R08
    rst_n |=> (lamps.power_indicator == $past(cond.power_good))
  ) else $error("power lamp does not follow supply");

  init_hold_a: assert property ( // R09
    (!st.init_done && st.loc == SIL_LOC_IDLE)
      |-> lamps.setup_activity_indicator
  ) else $error("setup lamp dark during initialization");

  tick_gap_a: assert property ( // R10
    (st.tick && st.prescale != '0) |=> !st.tick
  ) else $error("prescaler ticks too often");

  irq_level_a: assert property (
    ##1 (irq == |(st.status & st.mask))
  ) else $error("interrupt does not match masked status");

  // Read data must fall back to zero so a stale word is never mistaken
  rd_idle_zero_a: assert property (
    !rd_en |=> (rd_data == 32'h0)
  ) else $error("read data left standing without a read");

  // A read must empty the sticky bits it returned
  status_clear_a: assert property (
    (rd_en && addr == `SIL_OFF_STATUS && ev == '0)
      |=> (st.status == '0)
  ) else $error("status not cleared by its read");

  // Set beats clear: an event in the reading cycle must survive
  set_wins_a: assert property (
    (rst_n && ev != '0) |=> ((st.status & $past(ev)) == $past(ev))
  ) else $error("status event lost");

  irq_mask_a: assert property (
    (st.mask == '0 && !wr_en) |=> !irq
  ) else $error("interrupt raised with all events masked");

  mask_write_a: assert property (
    (wr_en && addr == `SIL_OFF_MASK)
      |=> (st.mask == $past(wr_data[`SIL_EV_W-1:0]))
  ) else $error("mask write did not land");

  prescale_write_a: assert property ( // R10
    (wr_en && addr == `SIL_OFF_PRESCALE)
      |=> (st.prescale == $past(wr_data[`SIL_PRESCALE_W-1:0]))
  ) else $error("prescale write did not land");

  blink_hold_a: assert property ( // R02
    !st.tick |=> $stable(st.blink_ph)
  ) else $error("blink phase moved without a tick");

  fault_first_a: assert property ( // R10
    (cond.fault && cond.warning) |=> lamps.error_indicator
  ) else $error("warning blink overrode a fault");

  flash_bound_a: assert property ( // R03
    st.flash_cnt <= FLASH_T
  ) else $error("flash counter beyond its length");

  // Locate overrides flash and setup, so both lamps track the pulse state
  locate_lamps_a: assert property ( // R04
    (st.loc != SIL_LOC_IDLE) |-> ((lamps.bus_activity_indicator
      == (st.loc == SIL_LOC_ON)) && (lamps.setup_activity_indicator
      == (st.loc == SIL_LOC_ON)))
  ) else $error("yellow lamps not pulsing together");

  // A zero count ends a phase on the next tick, the same as a count of one
  pulse_bound_a: assert property ( // R04
    (st.loc != SIL_LOC_IDLE)
      |-> (st.loc_cnt != '0 && st.loc_cnt <= PULSE_T)
  ) else $error("pulse counter out of range");

  // The default branch sends a bad code to idle at once, so both lamps keep their normal sources
  loc_onehot_a: assert property ( // R04
    $onehot(st.loc)
  ) else $error("locate state not one-hot");

  setup_dark_a: assert property ( // R05
    (!cond.setup_busy && st.init_done && st.loc == SIL_LOC_IDLE
      && !cond.locate) |=> !lamps.setup_activity_indicator
  ) else $error("setup lamp lit in normal mode");

  // Re-entering initialization would relight the setup lamp mid-run
  init_stay_a: assert property ( // R09
    st.init_done |=> st.init_done
  ) else $error("initialization hold restarted");

endmodule : sil_indicators
`default_nettype wire

// File: tb/sil_lamp_watch.sv
`timescale 1ns/100ps
`default_nettype none
// The operator at the front edge: counts how often each yellow lamp lights
module sil_lamp_watch (
  input  wire logic                   clk,
  input  wire sil_pkg::sil_lamps_type lamps,
  output var  logic [7:0]             bus_lits,
  output var  logic [7:0]             setup_lits
);
  import sil_pkg::*;
  logic bus_q;
  logic setup_q;
  initial begin
    bus_q = 1'b0;
    setup_q = 1'b0;
    bus_lits = 8'h0;
    setup_lits = 8'h0;
  end
  always @(posedge clk) begin
    bus_q <= lamps.bus_activity_indicator;
    setup_q <= lamps.setup_activity_indicator;
    if (lamps.bus_activity_indicator && !bus_q) bus_lits <= bus_lits + 8'h1;
    if (lamps.setup_activity_indicator && !setup_q) begin
      setup_lits <= setup_lits + 8'h1;
    end
  end
endmodule : sil_lamp_watch
`default_nettype wire

// File: tb/status_indicator_leds_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sil_params.svh"
module status_indicator_leds_tb_top;
  import sil_pkg::*;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  sil_cond_type           cond = '0;
  logic [`SIL_ADDR_W-1:0] addr = '0;
  logic [31:0]            wr_data = 32'h0;
  logic                   wr_en = 1'b0;
  logic                   rd_en = 1'b0;
  logic [31:0]            rd_data;
  logic                   irq;
  sil_lamps_type          lamps;
  logic [7:0]             bus_lits;
  logic [7:0]             setup_lits;
  logic [7:0]             b0;
  logic                   rd_q = 1'b0;
  logic [31:0]            exp_q[$];
  int                     err_total = 0;
  int                     checks = 0;
  int                     n;
  logic [31:0]            r;

  always #5 clk = ~clk;

  // Long counts shortened: 4 clocks a tick, 20 clocks of start-up
  sil_indicators #(.TICK_CYCLES(4), .INIT_CYCLES(20)) dut_u (
    .clk(clk), .rst_n(rst_n), .cond(cond), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .irq(irq), .lamps(lamps));
  sil_lamp_watch watch_u (.clk(clk), .lamps(lamps),
    .bus_lits(bus_lits), .setup_lits(setup_lits));

  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    checks++;
    if (act !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, act, exp);
    end
  endtask : chk

  task automatic chk_rd(input logic [31:0] act, input logic [31:0] exp);
    chk(act, exp);
  endtask : chk_rd

  task automatic wt(input int k);
    repeat (k) @(negedge clk);
  endtask : wt

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
  endtask : rd

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_q) begin
      chk_rd(rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : 32'hx);
    end
    rd_q <= rd_en;
  end

  // Counts lit cycles of the error lamp over k cycles
  task automatic err_lit(input int k);
    n = 0;
    repeat (k) begin
      @(negedge clk);
      if (lamps.error_indicator === 1'b1) n++;
    end
  endtask : err_lit

  task automatic print_verdict();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    r = $urandom(32'h36d92a4c);
    cond.power_good <= 1'b1;
    wt(3);
    chk(lamps, 9'h040);
    chk(irq, 1'b0);
    repeat (17) @(posedge clk);
    rst_n <= 1'b1;
    wt(5);
    chk({lamps.setup_activity_indicator, lamps.power_indicator}, 2'b11);
    wt(30);
    chk(lamps, 9'h020);
    rd(`SIL_OFF_STATE, 32'h620);
    rd(`SIL_OFF_PRESCALE, 32'h3);
    rd(4'h2, 32'h0);
    rd(`SIL_OFF_STATUS, 32'h0);
    wr(`SIL_OFF_STATUS, 32'hf);
    rd(`SIL_OFF_STATUS, 32'h0);
    r = $urandom;
    wr(`SIL_OFF_PRESCALE, {r[31:24], 24'h3});
    rd(`SIL_OFF_PRESCALE, 32'h3);
    wr(`SIL_OFF_MASK, r);
    rd(`SIL_OFF_MASK, {28'h0, r[3:0]});
    wr(`SIL_OFF_MASK, 32'hf);
    @(posedge clk) cond.input_valid <= 1'b1;
    wt(2);
    chk(lamps.input_valid_indicator, 1'b1);
    @(posedge clk) cond.input_valid <= 1'b0;
    wt(2);
    chk(lamps.input_valid_indicator, 1'b0);
    @(posedge clk) cond.fault <= 1'b1;
    wt(3);
    chk({lamps.error_indicator, irq}, 2'b11);
    rd(`SIL_OFF_STATUS, 32'h9);
    wt(3);
    chk(irq, 1'b0);
    @(posedge clk) cond.warning <= 1'b1;
    err_lit(1200);
    chk(n, 1200);
    @(posedge clk) cond.fault <= 1'b0;
    err_lit(2200);
    chk(n >= 950 && n <= 1250, 1'b1);
    @(posedge clk) cond.warning <= 1'b0;
    wt(2);
    chk(lamps.error_indicator, 1'b0);
    rd(`SIL_OFF_STATUS, 32'h2);
    @(posedge clk) cond.bus_activity <= 1'b1;
    @(posedge clk) cond.bus_activity <= 1'b0;
    wt(1);
    chk(lamps.bus_activity_indicator, 1'b1);
    n = 0;
    while (lamps.bus_activity_indicator === 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(n >= 195 && n <= 210, 1'b1);
    b0 = bus_lits;
    r[7:0] = setup_lits;
    @(posedge clk) cond.locate <= 1'b1;
    @(posedge clk) cond.locate <= 1'b0;
    wt(1);
    chk({lamps.bus_activity_indicator, irq}, 2'b11);
    wt(2600);
    chk({bus_lits - b0, setup_lits - r[7:0]}, 16'h0303);
    rd(`SIL_OFF_STATUS, 32'h4);
    @(posedge clk) cond.setup_busy <= 1'b1;
    wt(2);
    chk(lamps.setup_activity_indicator, 1'b1);
    @(posedge clk) cond.setup_busy <= 1'b0;
    @(posedge clk) cond.power_good <= 1'b0;
    wt(2);
    chk(lamps, 9'h000);
    wt(4);
    chk(exp_q.size(), 0);
    print_verdict();
  end
endmodule : status_indicator_leds_tb_top
`default_nettype wire
